/* File: reset_interrupt_sequencer.sv */
// Purpose: reset sources and interrupt arbitration for the core
// Assumes: core signals instruction boundary, stacking done and return events
// Notes: por_i is a level from the supply detector; osc_ok_i starts the delay
`timescale 1ns/1ns
module reset_interrupt_sequencer (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  input wire logic osc_ok_i,
  input wire logic reset_n_i,
  input wire logic watchdog_en_i,
  input wire logic wr_i,
  input wire logic [13:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] ext_int_line_i,
  input wire logic [2:0] ext_int_en_i,
  input wire logic [2:0] ext_level_mode_i,
  input wire logic core_timer_irq_i,
  input wire logic prog_timer_irq_i,
  input wire logic twowire_irq_i,
  input wire logic insn_done_i,
  input wire logic swi_fetch_i,
  input wire logic stack_done_i,
  input wire logic return_from_interrupt_i,
  input wire logic mask_clear_i,
  input wire logic mask_set_i,
  output logic cpu_reset_o,
  output logic watchdog_reset_o,
  output logic mask_bit_o,
  output logic take_irq_o,
  output logic push_regs_o,
  output logic pull_regs_o,
  output logic [13:0] vector_o
);
  typedef enum {S_RUN, S_STACK} seq_t;
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic [1:0] low_cnt;
    logic [rst_irq_pkg::CNT_W-1:0] por_cnt;
    logic por_hold;
    logic [rst_irq_pkg::CNT_W-1:0] wd_cnt;
    logic rst;
    logic wd_rst;
    logic mask;
    logic swi_pend;
    logic [2:0] pend_at_swi;
    logic take;
    logic push;
    logic pull;
    logic [13:0] vec;
    logic [2:0] ext_clr;
    seq_t st;
  } st_t;
  st_t q;
  st_t next_q;
  logic [2:0] ext_pend;
  logic [2:0] hw_ready;
  logic ext_any;

  genvar g;
  generate
    for (g = 0; g < rst_irq_pkg::NUM_EXT; g++) begin : g_ext
      ext_int_latch u_latch (
        .clk_i(clk_i),
        .srst_i(srst_i | q.rst),
        .pin_i(ext_int_line_i[g]),
        .level_mode_i(ext_level_mode_i[g]),
        .clear_i(q.ext_clr[g]),
        .pend_o(ext_pend[g])
      );
    end
  endgenerate

  assign ext_any = |(ext_pend & ext_int_en_i);
  // hw_ready: ext, core timer, two-wire, prog timer order after ext
  // six hardware sources
  assign hw_ready = {ext_any, core_timer_irq_i, twowire_irq_i | prog_timer_irq_i};

  always_comb begin
    next_q = q;
    next_q.take = 1'b0;
    next_q.push = 1'b0;
    next_q.pull = 1'b0;
    next_q.ext_clr = 3'h0;
    next_q.pin_s1 = reset_n_i;
    next_q.pin_s2 = q.pin_s1;
    if (q.pin_s2) begin
      next_q.low_cnt = 2'h0;
    end else if (q.low_cnt < 2'(rst_irq_pkg::PIN_LOW_CYC)) begin
      next_q.low_cnt = q.low_cnt + 2'h1;
    end
    if (por_i) begin
      next_q.por_hold = 1'b1;
      next_q.por_cnt = '0;
    end else if (q.por_hold && osc_ok_i) begin
      if (q.por_cnt >= rst_irq_pkg::CNT_W'(rst_irq_pkg::POR_DELAY_CYC - 1)) begin
        if (q.pin_s2) begin
          next_q.por_hold = 1'b0;
        end
      end else begin
        next_q.por_cnt = q.por_cnt + 1'b1;
      end
    end
    if (wr_i && wr_addr_i == rst_irq_pkg::WDOG_CLR_ADDR
        && !wr_data_i[rst_irq_pkg::WDOG_CLR_BIT]) begin
      next_q.wd_cnt = '0;
    end else if (q.rst || q.wd_rst || !watchdog_en_i) begin
      next_q.wd_cnt = '0;
    end else begin
      next_q.wd_cnt = q.wd_cnt + 1'b1;
    end
    next_q.wd_rst = watchdog_en_i && !q.rst && !q.wd_rst
      && q.wd_cnt >= rst_irq_pkg::CNT_W'(rst_irq_pkg::WDOG_CYC - 1);
    // combined reset sources
    // core reset follows the timeout pulse one cycle later; a pin low for
    // two synced cycles resets even if it rises right after
    next_q.rst = por_i || next_q.por_hold || q.wd_rst
      || (next_q.low_cnt >= 2'(rst_irq_pkg::PIN_LOW_CYC) && !q.pin_s2);
    // snapshot of requests pending at software interrupt fetch
    if (swi_fetch_i) begin
      next_q.swi_pend = 1'b1;
      next_q.pend_at_swi = q.mask ? 3'h0 : hw_ready;
    end
    if (mask_clear_i) begin
      next_q.mask = 1'b0;
    end
    if (mask_set_i) begin
      next_q.mask = 1'b1;
    end
    unique case (q.st)
      S_RUN: begin
        if (return_from_interrupt_i) begin
          next_q.pull = 1'b1;
        end
        if (insn_done_i) begin
          if (!q.mask && (!q.swi_pend || q.pend_at_swi != 3'h0) && hw_ready != 3'h0) begin
            next_q.take = 1'b1;
            if (hw_ready[2]) begin
              next_q.vec = rst_irq_pkg::VEC_EXT;
              next_q.ext_clr = ext_pend & ext_int_en_i;
            end else if (core_timer_irq_i) begin
              next_q.vec = rst_irq_pkg::VEC_CTIMER;
            end else if (twowire_irq_i) begin
              next_q.vec = rst_irq_pkg::VEC_TWOWIRE;
            end else begin
              next_q.vec = rst_irq_pkg::VEC_PTIMER;
            end
            next_q.pend_at_swi = 3'h0;
          end else if (q.swi_pend) begin
            next_q.take = 1'b1;
            next_q.vec = rst_irq_pkg::VEC_SWI;
            next_q.swi_pend = 1'b0;
          end
          if (next_q.take) begin
            next_q.push = 1'b1;
            next_q.mask = 1'b1;
            next_q.st = S_STACK;
          end
        end
      end
      S_STACK: begin
        if (stack_done_i) begin
          next_q.st = S_RUN;
        end
      end
    endcase
    // every reset source restarts the core here; mode held outside
    if (next_q.rst) begin
      next_q.mask = 1'b1;
      next_q.vec = rst_irq_pkg::VEC_RESET;
      next_q.st = S_RUN;
      next_q.swi_pend = 1'b0;
      next_q.pend_at_swi = 3'h0;
      next_q.take = 1'b0;
      next_q.push = 1'b0;
      next_q.pull = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '{pin_s1: 1'b1, pin_s2: 1'b1, low_cnt: 2'h0, por_cnt: '0, por_hold: 1'b1,
             wd_cnt: '0, rst: 1'b1, wd_rst: 1'b0, mask: 1'b1, swi_pend: 1'b0,
             pend_at_swi: 3'h0, take: 1'b0, push: 1'b0, pull: 1'b0,
             vec: rst_irq_pkg::VEC_RESET, ext_clr: 3'h0, st: S_RUN};
    end else begin
      q <= next_q;
    end
  end

  assign cpu_reset_o = q.rst;
  assign watchdog_reset_o = q.wd_rst;
  assign mask_bit_o = q.mask;
  assign take_irq_o = q.take;
  assign push_regs_o = q.push;
  assign pull_regs_o = q.pull;
  assign vector_o = q.vec;

  AST_TAKE_MASKS: assert property (@(posedge clk_i) disable iff (srst_i)
    take_irq_o |-> mask_bit_o && push_regs_o) else $error("take without mask/push");
  AST_RESET_VEC: assert property (@(posedge clk_i) disable iff (srst_i)
    cpu_reset_o |-> mask_bit_o && vector_o == 14'h3FFE) else $error("bad reset vector");
  AST_MASK_HOLDS: assert property (@(posedge clk_i) disable iff (srst_i)
    take_irq_o && vector_o != 14'h3FFC |-> !$past(q.mask)) else $error("masked irq taken");
  AST_BOUNDARY: assert property (@(posedge clk_i) disable iff (srst_i)
    take_irq_o |-> $past(insn_done_i)) else $error("irq off boundary");
  AST_WDOG_EN: assert property (@(posedge clk_i) disable iff (srst_i)
    watchdog_reset_o |-> $past(watchdog_en_i)) else $error("watchdog reset while off");
  AST_WDOG_RST: assert property (@(posedge clk_i) disable iff (srst_i)
    watchdog_reset_o |=> cpu_reset_o) else $error("watchdog no reset");
  AST_PIN_RST: assert property (@(posedge clk_i) disable iff (srst_i)
    !reset_n_i [*5] |-> cpu_reset_o) else $error("pin low no reset");
  AST_RTI_PULL: assert property (@(posedge clk_i) disable iff (srst_i)
    return_from_interrupt_i && q.st == S_RUN && !next_q.rst |=> pull_regs_o)
    else $error("return lost");
  AST_EXT_PRIO: assert property (@(posedge clk_i) disable iff (srst_i)
    take_irq_o && $past(hw_ready[2]) && !$past(q.mask)
    && $past(q.pend_at_swi != 3'h0 || !q.swi_pend)
    |-> vector_o == 14'h3FFA) else $error("ext priority");
  COV_EXT: cover property (@(posedge clk_i) take_irq_o && vector_o == 14'h3FFA);
  COV_SWI: cover property (@(posedge clk_i) take_irq_o && vector_o == 14'h3FFC);
  COV_WD: cover property (@(posedge clk_i) watchdog_reset_o);
endmodule : reset_interrupt_sequencer

/* File: rst_irq_pkg.sv */
// Purpose: shared constants for the reset and interrupt sequencer
// Assumes: 100 MHz machine clock, one cycle per machine cycle
// Notes: vector addresses are the high-byte location of each pair
package rst_irq_pkg;
  localparam int CLK_MHZ = 100;
  // power-on stabilization delay, in microseconds (plain default)
  localparam int POR_DELAY_US = 50;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  // least low time of the reset pin, in tenths of a machine cycle
  localparam int PIN_LOW_TENTHS = 15;
  localparam int PIN_LOW_CYC = (PIN_LOW_TENTHS + 9) / 10;
  // watchdog timeout in microseconds (plain default)
  localparam int WDOG_US = 100;
  localparam int WDOG_CYC = WDOG_US * CLK_MHZ;
  localparam logic [13:0] WDOG_CLR_ADDR = 14'h3FF0;
  localparam int WDOG_CLR_BIT = 0;
  localparam logic [13:0] VEC_RESET = 14'h3FFE;
  localparam logic [13:0] VEC_SWI = 14'h3FFC;
  localparam logic [13:0] VEC_EXT = 14'h3FFA;
  localparam logic [13:0] VEC_CTIMER = 14'h3FF8;
  localparam logic [13:0] VEC_TWOWIRE = 14'h3FF6;
  localparam logic [13:0] VEC_PTIMER = 14'h3FF4;
  localparam int NUM_EXT = 3;
  localparam int CNT_W = 24;
endpackage : rst_irq_pkg

/* File: ext_int_latch.sv */
// Purpose: one external interrupt line capture latch
// Assumes: pin is synchronous to clk_i
// Notes: falling edge sets the latch; low level also asserts when level mode
`timescale 1ns/1ns
module ext_int_latch (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  input wire logic level_mode_i,
  input wire logic clear_i,
  output logic pend_o
);
  typedef struct packed {
    logic prev;
    logic flag;
  } st_t;
  st_t q;
  st_t next_q;
  always_comb begin
    next_q = q;
    next_q.prev = pin_i;
    if (clear_i) begin
      next_q.flag = 1'b0;
    end
    // set wins over clear so a pulse in the clear cycle is kept
    if (q.prev && !pin_i) begin
      next_q.flag = 1'b1;
    end
    if (srst_i) begin
      next_q.flag = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // track the pin through reset so a line held low gives no false edge
      q <= '{prev: pin_i, flag: 1'b0};
    end else begin
      q <= next_q;
    end
  end
  assign pend_o = q.flag | (level_mode_i & ~pin_i & ~srst_i);
endmodule : ext_int_latch

/* File: core_model.sv */
// Purpose: core stand-in that answers each interrupt take
// Assumes: take and push arrive together as one-cycle pulses
// Notes: STACK_DLY picks a prompt or slow stacking answer
`timescale 1ns/1ns
module core_model #(
  parameter int STACK_DLY = 3
) (
  input wire logic clk_i,
  input wire logic take_irq_i,
  input wire logic push_regs_i,
  input wire logic [13:0] vector_i,
  output logic stack_done_o,
  output logic [13:0] takes_o,
  output logic [13:0] vec_o
);
  int wait_q = 0;
  initial begin
    stack_done_o = 1'b0;
    takes_o = 14'h0000;
    vec_o = 14'h0000;
  end
  always @(posedge clk_i) begin
    if (take_irq_i === 1'b1 && push_regs_i === 1'b1) begin
      takes_o <= takes_o + 14'h0001;
      vec_o <= vector_i;
      wait_q <= STACK_DLY;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
  // done is driven off the sampling edge so the block sees it settled
  always @(negedge clk_i) begin
    stack_done_o <= (wait_q == 1);
  end
endmodule : core_model

/* File: tb.sv */
// Purpose: self-checking bench for the reset and interrupt sequencer
// Assumes: core stand-in answers every take with stacking done
// Notes: full power-on and watchdog counts run, some 40k cycles
`timescale 1ns/1ns
module tb;
  localparam int P = rst_irq_pkg::POR_DELAY_CYC;
  localparam int W = rst_irq_pkg::WDOG_CYC;
  logic clk_i = 0, srst_i = 1, por_i = 1, osc_ok_i = 0, reset_n_i = 0;
  logic watchdog_en_i = 0, wr_i = 0, insn_done_i = 0, swi_fetch_i = 0, stack_done_i;
  logic return_from_interrupt_i = 0, mask_clear_i = 0, mask_set_i = 0;
  logic core_timer_irq_i = 0, prog_timer_irq_i = 0, twowire_irq_i = 0;
  logic [13:0] wr_addr_i = 14'h0000, vector_o, vec, takes, ntk = 14'h0000;
  logic [13:0] n_wdog = 14'h0000, n_pull = 14'h0000;
  logic [7:0] wr_data_i = 8'h00;
  logic [2:0] ext_int_line_i = 3'h7, ext_int_en_i = 3'h7, ext_level_mode_i = 3'h0;
  logic cpu_reset_o, watchdog_reset_o, mask_bit_o, take_irq_o, push_regs_o, pull_regs_o;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  reset_interrupt_sequencer i_reset_interrupt_sequencer (.clk_i, .srst_i, .por_i, .osc_ok_i,
    .reset_n_i, .watchdog_en_i, .wr_i, .wr_addr_i, .wr_data_i, .ext_int_line_i, .ext_int_en_i,
    .ext_level_mode_i, .core_timer_irq_i, .prog_timer_irq_i, .twowire_irq_i, .insn_done_i,
    .swi_fetch_i, .stack_done_i, .return_from_interrupt_i, .mask_clear_i, .mask_set_i,
    .cpu_reset_o, .watchdog_reset_o, .mask_bit_o, .take_irq_o, .push_regs_o, .pull_regs_o,
    .vector_o);
  core_model #(.STACK_DLY(3)) i_core_model (.clk_i, .take_irq_i(take_irq_o),
    .push_regs_i(push_regs_o), .vector_i(vector_o), .stack_done_o(stack_done_i),
    .takes_o(takes), .vec_o(vec));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cycles++;
    if (watchdog_reset_o === 1'b1) n_wdog <= n_wdog + 14'h0001;
    if (pull_regs_o === 1'b1) n_pull <= n_pull + 14'h0001;
    if (cycles == 4 * P + 5 * W) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic wait_lvl(input logic l, input int lim);
    for (int i = 0; i < lim && cpu_reset_o !== l; i++) cyc(1);
    chk(cpu_reset_o, l); // reset level reached
  endtask : wait_lvl
  task automatic pls(input int k);
    {return_from_interrupt_i, swi_fetch_i, mask_set_i, mask_clear_i} = 4'h1 << k;
    cyc(1);
    {return_from_interrupt_i, swi_fetch_i, mask_set_i, mask_clear_i} = 4'h0;
    cyc(2);
  endtask : pls
  task automatic bnd();
    insn_done_i = 1'b1;
    cyc(1);
    insn_done_i = 1'b0;
    cyc(6);
  endtask : bnd
  task automatic tk(input logic [13:0] v);
    bnd();
    ntk++;
    chk(takes, ntk); // one take
    chk(vec, v); // vector chosen
    chk(mask_bit_o, 1'b1); // mask set
  endtask : tk
  task automatic wrt(input logic [13:0] a, input logic [7:0] d);
    wr_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    cyc(1);
    wr_i = 1'b0;
    cyc(1);
  endtask : wrt
  task automatic t_por();
    por_i = 1'b0;
    cyc(100);
    osc_ok_i = 1'b1;
    cyc(P - 100);
    chk(cpu_reset_o, 1'b1); // delay holds
    cyc(300);
    chk(cpu_reset_o, 1'b1); // pin still low
    reset_n_i = 1'b1;
    wait_lvl(1'b0, 20);
    chk(vector_o, rst_irq_pkg::VEC_RESET); // start vector
    chk(mask_bit_o, 1'b1); // mask after reset
  endtask : t_por
  task automatic t_mask();
    pls(0);
    chk(mask_bit_o, 1'b0); // mask cleared
    pls(1);
    core_timer_irq_i = 1'b1;
    bnd();
    chk(takes, ntk); // held off
    pls(0);
    tk(rst_irq_pkg::VEC_CTIMER);
    core_timer_irq_i = 1'b0;
  endtask : t_mask
  task automatic t_prio();
    logic [3:0] src [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
    logic [13:0] ev [4] = '{rst_irq_pkg::VEC_EXT, rst_irq_pkg::VEC_CTIMER,
      rst_irq_pkg::VEC_TWOWIRE, rst_irq_pkg::VEC_PTIMER};
    for (int i = 0; i < 4; i++) begin
      pls(0);
      ext_int_line_i[1] = ~src[i][3];
      {core_timer_irq_i, twowire_irq_i, prog_timer_irq_i} = src[i][2:0];
      cyc(3);
      tk(ev[i]);
      ext_int_line_i[1] = 1'b1;
      {core_timer_irq_i, twowire_irq_i, prog_timer_irq_i} = 3'h0;
    end
  endtask : t_prio
  task automatic t_ext();
    for (int j = 0; j < 3; j++) begin
      pls(0);
      ext_int_line_i[j] = 1'b0;
      cyc(3);
      tk(rst_irq_pkg::VEC_EXT);
      // second pulse lands while masked in service
      ext_int_line_i[j] = 1'b1;
      cyc(2);
      ext_int_line_i[j] = 1'b0;
      cyc(2);
      ext_int_line_i[j] = 1'b1;
      pls(0);
      tk(rst_irq_pkg::VEC_EXT);
      pls(0);
      bnd();
      chk(takes, ntk); // latch emptied
    end
    // a disabled line latches but waits until it is enabled
    ext_int_en_i[1] = 1'b0;
    ext_int_line_i[1] = 1'b0;
    cyc(3);
    bnd();
    chk(takes, ntk); // source disabled
    ext_int_line_i[1] = 1'b1;
    ext_int_en_i[1] = 1'b1;
    tk(rst_irq_pkg::VEC_EXT);
    // level mode keeps a held-low line pending after the latch clears
    ext_level_mode_i[2] = 1'b1;
    pls(0);
    ext_int_line_i[2] = 1'b0;
    cyc(3);
    tk(rst_irq_pkg::VEC_EXT);
    pls(0);
    tk(rst_irq_pkg::VEC_EXT);
    ext_int_line_i[2] = 1'b1;
    ext_level_mode_i[2] = 1'b0;
    pls(0);
    bnd();
    chk(takes, ntk); // level released
  endtask : t_ext
  task automatic t_soft();
    pls(1);
    pls(2);
    tk(rst_irq_pkg::VEC_SWI);
    pls(0);
    prog_timer_irq_i = 1'b1;
    cyc(2);
    pls(2);
    tk(rst_irq_pkg::VEC_PTIMER);
    prog_timer_irq_i = 1'b0;
    tk(rst_irq_pkg::VEC_SWI);
    pls(3);
    chk(n_pull, 14'h0001); // registers pulled
  endtask : t_soft
  task automatic t_pin();
    ext_int_line_i[0] = 1'b0;
    cyc(3);
    reset_n_i = 1'b0;
    cyc(2);
    reset_n_i = 1'b1;
    ext_int_line_i[0] = 1'b1;
    wait_lvl(1'b1, 8);
    wait_lvl(1'b0, P + 100);
    chk(vector_o, rst_irq_pkg::VEC_RESET); // start vector
    pls(0);
    bnd();
    chk(takes, ntk); // latch flushed
  endtask : t_pin
  task automatic t_wdog();
    watchdog_en_i = 1'b1;
    wrt(14'h3FF0, 8'h00);
    repeat (2) begin
      cyc(W * 7 / 10);
      wrt(14'h3FF0, 8'h00);
    end
    chk(n_wdog, 14'h0000); // clears keep off
    cyc(W / 4);
    wrt(14'h3FF1, 8'h00);
    cyc(W / 4);
    wrt(14'h3FF0, 8'h01);
    cyc(W / 2 - 160);
    chk(n_wdog, 14'h0000); // not early
    for (int i = 0; i < 300 && n_wdog == 14'h0000; i++) cyc(1);
    chk(n_wdog, 14'h0001); // timeout fired
    wait_lvl(1'b1, 3);
    watchdog_en_i = 1'b0;
    wait_lvl(1'b0, P + 100);
    cyc(W + 100);
    chk(n_wdog, 14'h0001); // disabled quiet
  endtask : t_wdog
  initial begin
    cyc(6);
    srst_i = 1'b0;
    t_por();
    t_mask();
    t_prio();
    t_ext();
    t_soft();
    t_pin();
    t_wdog();
    summarize();
  end
endmodule : tb
